// ==== src/pic_arbiter.sv ====
// ranking logic: picks the winning pending request by level then by fixed source order
// assumes flags and enables are stable registered values
`timescale 1ns/100ps
module pic_arbiter (
	input wire logic [6:0] pend_i, // pending flags
	input wire logic [6:0] en_high_i, // priority_enable_high
	input wire logic [6:0] en_low_i, // priority_enable_low
	output logic found_o, // some pending request is enabled
	output logic [2:0] src_o, // winning source index
	output logic [1:0] lvl_o // winning level
);
	import pic_pkg::*;
	logic [1:0] lvl [PIC_NSRC];

	// ==========================================
	// per source level
	genvar g;
	generate
		for (g = 0; g < PIC_NSRC; g++) begin : g_lvl
			assign lvl[g] = pend_i[g] ? {en_high_i[g], en_low_i[g]} : 2'h0;
		end
	endgenerate

	// ==========================================
	// scan from lowest bit up; greater-or-equal compare lets higher bits win ties and keeps level order
	always_comb begin
		found_o = 1'b0;
		src_o = 3'h0;
		lvl_o = 2'h0;
		for (int i = 0; i < PIC_NSRC; i++) begin
			if (lvl[i] != 2'h0 && lvl[i] >= lvl_o) begin
				found_o = 1'b1;
				src_o = i[2:0];
				lvl_o = lvl[i];
			end
		end
	end
endmodule : pic_arbiter

// ==== src/pic_pkg.sv ====
// package for the prioritized interrupt controller: register map, fields, reset values, carriers
// assumes a classic wishbone slave with 32-bit data and byte addresses
package pic_pkg;
	// ==========================================
	// register offsets (byte addresses)
	localparam logic [11:0] PIC_OFF_FLAGS = 12'hFC0; // peripheral_request_flags
	localparam logic [11:0] PIC_OFF_EN_HIGH = 12'hFC4; // priority_enable_high
	localparam logic [11:0] PIC_OFF_EN_LOW = 12'hFC8; // priority_enable_low
	localparam logic [11:0] PIC_OFF_CTRL = 12'hFCC; // global enable and vector state
	// ==========================================
	// field layout and reset values
	localparam int PIC_NSRC = 7; // peripheral sources, bit 6 timer 1 down to bit 0 adc
	localparam int PIC_CTRL_GIE_BIT = 7; // global_irq_enable position in control word
	localparam logic [7:0] PIC_FLAGS_RST = 8'h00;
	localparam logic [7:0] PIC_EN_RST = 8'h00;
	localparam logic PIC_GIE_RST = 1'b0;
	localparam logic [7:0] PIC_VEC_BASE = 8'h0A; // vector address of the top-ranked source
	localparam logic [7:0] PIC_VEC_STEP = 8'h02;
	localparam logic [31:0] PIC_UNMAPPED_DATA = 32'h0000_0000;
	localparam int PIC_ACK_CYCLES = 1; // cycles from request to ack

	// cpu side events
	typedef struct packed {
		logic enable_interrupts_instr; // enable instruction executed
		logic disable_interrupts_instr; // disable instruction executed
		logic return_from_interrupt_instr; // return from interrupt executed
		logic trap_instr; // trap instruction executed
		logic illegal_trap; // illegal instruction trap taken
		logic irq_ack; // cpu acknowledges the presented request
	} pic_cpu_s;

	// vectored request towards the cpu
	typedef struct packed {
		logic valid; // a request is presented
		logic [2:0] source; // winning flag bit index
		logic [1:0] level; // priority level 1..3
		logic [7:0] vector; // low byte of vector address
	} pic_req_s;
endpackage : pic_pkg

// ==== src/pic_top.sv ====
// prioritized interrupt controller: request flags, enables, global enable, vectored request
// assumes one 20 MHz clock, synchronous reset, classic wishbone master, cpu core on pic_cpu_s
//
// Contract
// - one global enable gates all vectored delivery to the cpu
// - enable instruction, return from interrupt or write 1 sets global enable
// - disable, acknowledge, write 0, reset, trap or illegal trap clears it
// - level 3 beats level 2, level 2 beats level 1
// - equal levels resolve by the fixed source order
// - order: timer1, timer0, uart rx, uart tx, two-wire, spi, then adc
// - reset, watchdog and illegal trap outrank every programmable interrupt
// - one-cycle request pulses are latched into persistent flags
// - a request pulse sets its source flag
// - acknowledge clears the winning source flag until a new request
// - software writing 0 clears a flag
// - software writing 1 makes a pending request, serviced and cleared normally
// - with global enable set, the winner is presented as a vectored request
// - flag bits: 6 timer1, 5 timer0, 4 rx, 3 tx, 2 two-wire, 1 spi, 0 adc
// - watchdog is handled outside these registers; the rest are governed here
// - enable high-low pair: 00 off, 01 level 1, 10 level 2, 11 level 3
`timescale 1ns/100ps
module pic_top (
	input wire logic clk_i, // 20 MHz system clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic ce_i, // clock enable, freezes state when low
	input wire logic [6:0] src_pulse_i, // one-cycle request pulses, bit map as flags
	input wire pic_pkg::pic_cpu_s cpu_i, // cpu instruction events and acknowledge
	output pic_pkg::pic_req_s req_o, // vectored request to cpu
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write enable
	input wire logic [11:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte selects
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o // wishbone acknowledge
);
	import pic_pkg::*;

	// ==========================================
	// state
	typedef struct packed {
		logic [6:0] flags; // peripheral_request_flags
		logic [6:0] en_high; // priority_enable_high
		logic [6:0] en_low; // priority_enable_low
		logic gie; // global_irq_enable
		logic ack; // bus acknowledge
		logic [31:0] rdata; // bus read data
		pic_req_s req; // registered vectored request
	} pic_state_s;

	pic_state_s st;
	pic_state_s next_st;
	logic found;
	logic [2:0] win_src;
	logic [1:0] win_lvl;
	logic bus_req;
	logic wr_lane0;
	logic [7:0] wbyte;
	logic [6:0] ack_clr;

	// ==========================================
	// ranking
	pic_arbiter u_arb (
		.pend_i(st.flags),
		.en_high_i(st.en_high),
		.en_low_i(st.en_low),
		.found_o(found),
		.src_o(win_src),
		.lvl_o(win_lvl)
	);

	// bus decode helpers; registers sit in the 8 bits of lane 0
	assign bus_req = wb_cyc_i && wb_stb_i && !st.ack;
	assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];
	// acknowledge clears only the source being presented
	assign ack_clr = (cpu_i.irq_ack && st.req.valid) ? 7'(1 << st.req.source) : 7'h00;

	// ==========================================
	// next state
	always_comb begin
		next_st = st;
		next_st.ack = bus_req;
		next_st.rdata = PIC_UNMAPPED_DATA;
		// flags: software write first, then acknowledge clear, then hardware set wins
		if (wr_lane0 && wb_adr_i == PIC_OFF_FLAGS) begin
			next_st.flags = wbyte[6:0];
		end
		next_st.flags = next_st.flags & ~ack_clr;
		next_st.flags = next_st.flags | src_pulse_i;
		if (wr_lane0 && wb_adr_i == PIC_OFF_EN_HIGH) begin
			next_st.en_high = wbyte[6:0];
		end
		if (wr_lane0 && wb_adr_i == PIC_OFF_EN_LOW) begin
			next_st.en_low = wbyte[6:0];
		end
		// global enable: later assignments win, so clearing events dominate sets
		if (cpu_i.enable_interrupts_instr || cpu_i.return_from_interrupt_instr) begin
			next_st.gie = 1'b1;
		end
		if (wr_lane0 && wb_adr_i == PIC_OFF_CTRL) begin
			next_st.gie = wbyte[PIC_CTRL_GIE_BIT];
		end
		if (cpu_i.disable_interrupts_instr || cpu_i.trap_instr || cpu_i.illegal_trap
				|| (cpu_i.irq_ack && st.req.valid)) begin
			next_st.gie = 1'b0;
		end
		// read mux
		if (bus_req && !wb_we_i) begin
			unique case (wb_adr_i)
				PIC_OFF_FLAGS: next_st.rdata = {25'h0, st.flags};
				PIC_OFF_EN_HIGH: next_st.rdata = {25'h0, st.en_high};
				PIC_OFF_EN_LOW: next_st.rdata = {25'h0, st.en_low};
				PIC_OFF_CTRL: next_st.rdata = {16'h0, st.req.vector, st.gie, 1'h0, st.req.valid,
						st.req.level, st.req.source};
				default: next_st.rdata = PIC_UNMAPPED_DATA;
			endcase
		end
		// vectored request, dropped while an illegal trap is taken
		next_st.req.valid = next_st.gie && found && !cpu_i.illegal_trap && !ack_clr[win_src];
		next_st.req.source = win_src;
		next_st.req.level = win_lvl;
		next_st.req.vector = PIC_VEC_BASE + PIC_VEC_STEP * 8'(3'd6 - win_src);
		if (rst_i) begin
			next_st = '0;
			next_st.flags = PIC_FLAGS_RST[6:0];
			next_st.en_high = PIC_EN_RST[6:0];
			next_st.en_low = PIC_EN_RST[6:0];
			next_st.gie = PIC_GIE_RST;
		end
	end

	// ==========================================
	// registers; reset passes even when ce is low so the block never starts undefined
	always_ff @(posedge clk_i) begin
		if (ce_i || rst_i) begin
			st <= next_st;
		end
	end

	assign req_o = st.req;
	assign wb_dat_o = st.rdata;
	assign wb_ack_o = st.ack;

	// ==========================================
	// checks
	sequence gie_set_ev;
		ce_i && (cpu_i.enable_interrupts_instr || cpu_i.return_from_interrupt_instr) && !cpu_i.disable_interrupts_instr
			&& !cpu_i.trap_instr && !cpu_i.illegal_trap && !cpu_i.irq_ack && !(wr_lane0 && wb_adr_i == PIC_OFF_CTRL);
	endsequence

	sequence ack_ev;
		ce_i && cpu_i.irq_ack && st.req.valid;
	endsequence

	gie_set_a: assert property (@(posedge clk_i) disable iff (rst_i) gie_set_ev |=> st.gie)
		else $error("global enable not set by instruction");
	gie_ack_a: assert property (@(posedge clk_i) disable iff (rst_i) ack_ev |=> !st.gie && !req_o.valid)
		else $error("global enable not cleared by acknowledge");
	gie_block_a: assert property (@(posedge clk_i) disable iff (rst_i) !st.gie |-> !req_o.valid)
		else $error("request presented while globally disabled");
	pulse_set_a: assert property (@(posedge clk_i) disable iff (rst_i) ce_i && src_pulse_i[6] |=> st.flags[6])
		else $error("request pulse not latched");
	set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
			ce_i && src_pulse_i[0] && wr_lane0 && wb_adr_i == PIC_OFF_FLAGS && !wbyte[0] |=> st.flags[0])
		else $error("hardware set lost to software clear");
	ack_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
			(ack_ev and !src_pulse_i[st.req.source]) |=> !st.flags[$past(st.req.source)])
		else $error("acknowledged flag not cleared");
	sw_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
			ce_i && wr_lane0 && wb_adr_i == PIC_OFF_FLAGS && !wbyte[3] && !src_pulse_i[3] |=> !st.flags[3])
		else $error("software clear ignored");
	level_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
			req_o.valid |-> req_o.level == {st.en_high[req_o.source], st.en_low[req_o.source]} || $changed(st.en_high)
			|| $changed(st.en_low))
		else $error("presented level disagrees with enables");
	bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i) ce_i && bus_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle");

	// ==========================================
	// further event sequences
	// a disable, trap or illegal trap event that forces global enable low in the next cycle
	sequence gie_kill_ev;
		ce_i && (cpu_i.disable_interrupts_instr || cpu_i.trap_instr || cpu_i.illegal_trap);
	endsequence

	// a control register write seen on the bus
	sequence ctrl_wr_ev;
		ce_i && wr_lane0 && wb_adr_i == PIC_OFF_CTRL;
	endsequence

	// global enable will stay set and nothing withdraws the winner
	sequence present_ev;
		ce_i && st.gie && found && !cpu_i.disable_interrupts_instr && !cpu_i.trap_instr
			&& !cpu_i.illegal_trap && !cpu_i.irq_ack && !(wr_lane0 && wb_adr_i == PIC_OFF_CTRL);
	endsequence

	// a read request that the bus logic takes
	sequence rd_take_ev;
		ce_i && bus_req && !wb_we_i;
	endsequence

	// ==========================================
	// global enable checks
	// a control write of one sets the enable unless a clear event races it
	gie_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
			(ctrl_wr_ev and wbyte[PIC_CTRL_GIE_BIT] && !cpu_i.disable_interrupts_instr && !cpu_i.trap_instr
			&& !cpu_i.illegal_trap && !(cpu_i.irq_ack && st.req.valid)) |=> st.gie)
		else $error("global enable not set by write");

	// a control write of zero wins over any set instruction
	gie_wrzero_a: assert property (@(posedge clk_i) disable iff (rst_i)
			(ctrl_wr_ev and !wbyte[PIC_CTRL_GIE_BIT]) |=> !st.gie)
		else $error("global enable not cleared by write");

	// disable, trap and illegal trap always clear, whatever else happens
	gie_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
			gie_kill_ev |=> !st.gie)
		else $error("global enable not cleared by instruction");

	// an acknowledge with nothing presented is refused and leaves the enable alone
	ack_refused_a: assert property (@(posedge clk_i) disable iff (rst_i)
			ce_i && cpu_i.irq_ack && !st.req.valid && st.gie && !cpu_i.disable_interrupts_instr
			&& !cpu_i.trap_instr && !cpu_i.illegal_trap && !(wr_lane0 && wb_adr_i == PIC_OFF_CTRL) |=> st.gie)
		else $error("stray acknowledge cleared global enable");

	// reset brings every piece of state to its quiet value
	reset_quiet_a: assert property (@(posedge clk_i) rst_i |=> st.flags == 7'h00 && !st.gie
			&& !req_o.valid && !wb_ack_o)
		else $error("reset left state behind");

	// ==========================================
	// presentation checks
	// the illegal trap outranks any programmable request in the next cycle
	trap_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
			ce_i && cpu_i.illegal_trap |=> !req_o.valid)
		else $error("request presented over illegal trap");

	// an enabled winner with enable kept is presented one cycle later
	present_win_a: assert property (@(posedge clk_i) disable iff (rst_i)
			present_ev |=> req_o.valid && req_o.source == $past(win_src))
		else $error("winning request not presented");

	// vector follows the fixed table spacing from the top source
	vector_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
			req_o.valid |-> req_o.vector == PIC_VEC_BASE + PIC_VEC_STEP * (8'h06 - 8'(req_o.source)))
		else $error("vector does not match source");

	// a disabled pair never reaches the cpu
	level_nonzero_a: assert property (@(posedge clk_i) disable iff (rst_i)
			req_o.valid |-> req_o.level != 2'h0)
		else $error("request presented at level zero");

	// ==========================================
	// ranking checks, on the arbiter outputs of the same cycle
	// any pending level 3 source forces a level 3 winner
	top_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
			found && win_lvl != 2'h3 |-> (st.flags & st.en_high & st.en_low) == 7'h00)
		else $error("level 3 request lost arbitration");

	// a level 1 winner means nothing at level 2 or 3 is pending
	low_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
			found && win_lvl == 2'h1 |-> (st.flags & st.en_high) == 7'h00)
		else $error("level 1 won over a higher level");

	// timer 1 heads the fixed order, so it loses only to a strictly higher level
	tie_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
			found && win_src != 3'h6 && st.flags[6] && {st.en_high[6], st.en_low[6]} != 2'h0
			|-> win_lvl > {st.en_high[6], st.en_low[6]})
		else $error("fixed source order broken");

	// any pending enabled source must be found
	found_any_a: assert property (@(posedge clk_i) disable iff (rst_i)
			(st.flags & (st.en_high | st.en_low)) != 7'h00 |-> found)
		else $error("pending enabled request not found");

	// the winner is always a pending source
	win_pending_a: assert property (@(posedge clk_i) disable iff (rst_i)
			found |-> st.flags[win_src])
		else $error("winner has no pending flag");

	// ==========================================
	// flag and enable register checks
	// software write of one raises a request unless an acknowledge clears it
	sw_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
			ce_i && wr_lane0 && wb_adr_i == PIC_OFF_FLAGS && wbyte[5] && !cpu_i.irq_ack |=> st.flags[5])
		else $error("software set ignored");

	// a flag persists with no pulse, write or acknowledge
	flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
			ce_i && !src_pulse_i[1] && !wr_lane0 && !cpu_i.irq_ack |=> st.flags[1] == $past(st.flags[1]))
		else $error("flag changed by itself");

	// lane 0 off means the write never lands
	sel_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
			ce_i && bus_req && wb_we_i && !wb_sel_i[0] && src_pulse_i == 7'h00 && !cpu_i.irq_ack
			|=> st.flags == $past(st.flags))
		else $error("write with lane off changed flags");

	// enable low register takes the written byte
	en_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
			ce_i && wr_lane0 && wb_adr_i == PIC_OFF_EN_LOW |=> st.en_low == $past(wbyte[6:0]))
		else $error("enable write lost");

	// low clock enable freezes everything, pulses and bus alike
	freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
			!ce_i |=> $stable(st))
		else $error("state moved while clock enable low");

	// ==========================================
	// read path checks
	// polling reads return the flags with the reserved bits at zero
	rd_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
			(rd_take_ev and wb_adr_i == PIC_OFF_FLAGS) |=> wb_dat_o == {25'h0, $past(st.flags)})
		else $error("flag read wrong");

	// control reads show the enable in its documented bit
	rd_ctrl_a: assert property (@(posedge clk_i) disable iff (rst_i)
			(rd_take_ev and wb_adr_i == PIC_OFF_CTRL) |=> wb_dat_o[PIC_CTRL_GIE_BIT] == $past(st.gie))
		else $error("control read wrong");

	// unmapped reads are still answered, with zero
	rd_unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
			(rd_take_ev and wb_adr_i != PIC_OFF_FLAGS && wb_adr_i != PIC_OFF_EN_HIGH
			&& wb_adr_i != PIC_OFF_EN_LOW && wb_adr_i != PIC_OFF_CTRL) |=> wb_dat_o == PIC_UNMAPPED_DATA)
		else $error("unmapped read not zero");

	// read data only stands beside its acknowledge, so a stale word is never seen
	bus_dat_a: assert property (@(posedge clk_i) disable iff (rst_i)
			!wb_ack_o |-> wb_dat_o == PIC_UNMAPPED_DATA)
		else $error("read data outside acknowledge");
endmodule : pic_top

// ==== verification/pic_cpu_model.sv ====
// partner model: cpu core that acknowledges vectored requests after a chosen lag
// assumes the controller drops valid in the cycle after an acknowledge
`timescale 1ns/100ps
module pic_cpu_model (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire pic_pkg::pic_req_s req_i, // vectored request
	input wire logic [1:0] lag_i, // wait cycles before acknowledging
	input wire pic_pkg::pic_cpu_s instr_i, // instruction events from the bench
	output pic_pkg::pic_cpu_s cpu_o // events towards the controller
);
	import pic_pkg::*;
	logic ack;
	logic [1:0] cnt;
	// ==========
	// acknowledge
	// one pulse per request, so a stale valid is never taken twice
	always_ff @(posedge clk_i) begin
		if (rst_i || !req_i.valid || ack) begin
			ack <= 1'b0;
			cnt <= 2'h0;
		end else if (cnt == lag_i) begin
			ack <= 1'b1;
		end else begin
			cnt <= cnt + 2'h1;
		end
	end
	// instruction events pass beside the acknowledge
	always_comb begin
		cpu_o = instr_i;
		cpu_o.irq_ack = ack;
	end
endmodule : pic_cpu_model

// ==== verification/pic_top_tb.sv ====
// bench for the interrupt controller: wishbone tasks, request pulses, cpu model
// assumes a one-cycle registered ack and the cpu model on the request side
`timescale 1ns/100ps
module pic_top_tb;
	import pic_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [6:0] src_pulse_i = 7'h00;
	logic [3:0] sel = 4'hF;
	logic [1:0] lag = 2'h0;
	logic ce = 1'b1;
	pic_cpu_s instr = '0;
	pic_cpu_s cpu;
	pic_req_s req_o;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [31:0] q;
	pic_cpu_s setv [2] = '{6'h20, 6'h08};
	pic_cpu_s clrv [3] = '{6'h10, 6'h04, 6'h02};
	logic [2:0] srcs [5] = '{3'h2, 3'h3, 3'h6, 3'h4, 3'h0};
	logic [1:0] lvls [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h1};
	int num_errors = 0;
	int compares = 0;
	always #25 clk_i = ~clk_i;
	pic_top pic_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .src_pulse_i(src_pulse_i), .cpu_i(cpu),
		.req_o(req_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	pic_cpu_model pic_cpu_model_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_o), .lag_i(lag),
		.instr_i(instr), .cpu_o(cpu));
	// ==========
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic final_report();
		if (num_errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report
	task automatic give_up(input logic ok);
		chk({31'h0, ok}, 32'h1, "timeout");
		if (!ok) begin
			final_report();
		end
	endtask : give_up
	// one classic cycle; pulses ride on the taking edge to race a write
	task automatic bus(input logic we, input logic [11:0] a, input logic [7:0] d, input logic [6:0] p);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= sel;
		wb_dat_i <= {24'h000000, d};
		src_pulse_i <= p;
		@(posedge clk_i);
		src_pulse_i <= 7'h00;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		give_up(wb_ack_o === 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : bus
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
		bus(1'b0, a, 8'h00, 7'h00);
		chk(q, e, m);
	endtask : rdc
	task automatic rgie(input logic e, input string m);
		bus(1'b0, PIC_OFF_CTRL, 8'h00, 7'h00);
		chk({31'h0, q[PIC_CTRL_GIE_BIT]}, {31'h0, e}, m);
	endtask : rgie
	task automatic ev(input pic_cpu_s v);
		@(posedge clk_i);
		instr <= v;
		@(posedge clk_i);
		instr <= '0;
	endtask : ev
	task automatic wreq(input logic v);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (req_o.valid !== v && n < 20);
		give_up(req_o.valid === v);
	endtask : wreq
	// ==========
	// main sequence
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(PIC_OFF_FLAGS, 32'h0, "flags reset");
		rdc(PIC_OFF_EN_LOW, 32'h0, "enable reset");
		rdc(12'h004, 32'h0, "unmapped read");
		// each pulse lands in its own bit; a zero write clears it
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, PIC_OFF_FLAGS, 8'h00, 7'(1 << i));
			rdc(PIC_OFF_FLAGS, 32'(1 << i), "pulse to flag");
			bus(1'b1, PIC_OFF_FLAGS, 8'h00, 7'h00);
		end
		bus(1'b1, PIC_OFF_FLAGS, 8'h00, 7'h10);
		rdc(PIC_OFF_FLAGS, 32'h10, "set beats clear");
		sel = 4'h0;
		bus(1'b1, PIC_OFF_FLAGS, 8'h00, 7'h00);
		sel = 4'hF;
		rdc(PIC_OFF_FLAGS, 32'h10, "sel off write");
		bus(1'b1, PIC_OFF_FLAGS, 8'h00, 7'h00);
		// global enable: each instruction set and clear event, then a write of one and of zero
		for (int k = 0; k < 3; k++) begin
			ev(setv[k % 2]);
			rgie(1'b1, "gie set");
			ev(clrv[k]);
			rgie(1'b0, "gie clear");
		end
		bus(1'b1, PIC_OFF_CTRL, 8'h80, 7'h00);
		rgie(1'b1, "gie write one");
		bus(1'b1, PIC_OFF_CTRL, 8'h00, 7'h00);
		rgie(1'b0, "gie write zero");
		// src2 level 3, src3 level 2, src6/4/0 level 1, src5 and src1 off
		bus(1'b1, PIC_OFF_EN_HIGH, 8'h0C, 7'h00);
		bus(1'b1, PIC_OFF_EN_LOW, 8'h55, 7'h00);
		bus(1'b1, PIC_OFF_FLAGS, 8'h7F, 7'h00);
		chk({31'h0, req_o.valid}, 32'h0, "request while gie clear");
		rdc(PIC_OFF_FLAGS, 32'h7F, "polled flags");
		for (int k = 0; k < 5; k++) begin
			lag <= 2'(k);
			ev(setv[k % 2]);
			wreq(1'b1);
			chk({29'h0, req_o.source}, {29'h0, srcs[k]}, "winner");
			chk({30'h0, req_o.level}, {30'h0, lvls[k]}, "level");
			chk({24'h0, req_o.vector}, 32'h0A + 32'h2 * (32'h6 - srcs[k]), "vector");
			wreq(1'b0);
			rgie(1'b0, "gie after ack");
		end
		rdc(PIC_OFF_FLAGS, 32'h22, "flags left");
		// a pulse while clock enable is low is frozen out
		@(posedge clk_i);
		ce <= 1'b0;
		src_pulse_i <= 7'h40;
		@(posedge clk_i);
		ce <= 1'b1;
		src_pulse_i <= 7'h00;
		rdc(PIC_OFF_FLAGS, 32'h22, "frozen pulse");
		final_report();
	end
endmodule : pic_top_tb
